// File: hw/area_bus_ctrl.sv
// area external bus controller: registers, arbiter, external cycle sequencer
// assumes synchronous pins, one 200 MHz clock, masters hold requests until done
//
// What this block does
// - advanced mode splits space into eight areas of 128K or 2M
// - four active-low chip selects for areas 0-3, only during own access
// - address strobe marks valid external address
// - read strobe active during an external read
// - upper write strobe when bits 15:8 carry write data
// - lower write strobe when bits 7:0 carry write data
// - wait input honoured only in 3-state areas
// - external bus request releases the bus
// - acknowledge asserted once bus is actually released
// - reclaim request when internal master needs bus while released
// - arbiter grants bus between cpu and transfer controller
// - width bit 0 gives 16-bit, 1 gives 8-bit area
// - normal mode uses only area 0 settings
// - state bit 0 gives 2-state no waits, 1 gives 3-state with waits
// - wait field gives zero to three program waits in 3-state areas
// - no program waits for on-chip accesses
// - width reg resets to ones, zeros in mode 4; kept otherwise
// - state reg resets to ones
// - both wait regs reset to ones
// - optional idle cycle between reads of different areas
// - optional idle cycle before write following a read
// - area 0 burst rom cycles take 2 or 3 states
// - burst rom forces 16-bit bus mode
`timescale 1ns/1ps
`default_nettype none
module area_bus_ctrl
	import area_bus_pkg::*;
(
	// clock, reset and mode straps
	input  wire logic        I_CLK,
	input  wire logic        I_RST,
	input  wire logic [2:0]  I_MCU_MODE,
	input  wire logic        I_ADVANCED,
	// avalon-mm register port
	input  wire logic [15:0] I_AVS_ADDRESS,
	input  wire logic        I_AVS_READ,
	input  wire logic        I_AVS_WRITE,
	input  wire logic [7:0]  I_AVS_WRITEDATA,
	output logic [7:0]       O_AVS_READDATA,
	output logic             O_AVS_WAITREQUEST,
	// internal masters and 16-bit bus mode flag
	input  wire master_req_t I_CPU,
	input  wire master_req_t I_XFER,
	output logic             O_CPU_DONE,
	output logic             O_XFER_DONE,
	output logic             O_BURST_16,
	// external bus
	input  wire logic        I_WAIT_N,
	input  wire logic        I_EXT_MASTER_REQUEST_N,
	output logic             O_BUS_ACK_N,
	output logic             O_RECLAIM_REQUEST_N,
	output logic [23:0]      O_ADDR,
	output logic [15:0]      O_DATA_OUT,
	output logic             O_DATA_OE,
	output strobes_t         O_STROBES
);

	typedef struct packed {
		logic [7:0]  width;
		logic [7:0]  state_bits;
		logic [7:0]  wait_hi;
		logic [7:0]  wait_lo;
		logic [7:0]  ctrl_hi;
		logic [7:0]  ctrl_lo;
		logic        init_done;
		logic        rd_ack;
		logic [7:0]  rdata;
		bus_state_t  fsm;
		logic        owner;
		logic        wr;
		logic [1:0]  be;
		logic [2:0]  area;
		logic        two_state;
		logic        honour_wait;
		logic [1:0]  pwait;
		logic [23:0] addr;
		logic [15:0] wdata;
		logic        last_rd;
		logic [2:0]  last_area;
		logic        done_cpu;
		logic        done_xfer;
		strobes_t    strobes;
		logic        ack_n;
	} regs_t;

	regs_t r;
	regs_t next_r;

	// area number from address, unit chosen by the partition bit
	function automatic logic [2:0] area_of(input logic [23:0] a, input logic big);
		area_of = big ? a[AREA_LSB_2M +: 3] : a[AREA_LSB_128K +: 3];
	endfunction

	function automatic logic [1:0] wait_field(input logic [15:0] w, input logic [2:0] n);
		wait_field = w[{n, 1'b0} +: 2];
	endfunction

	master_req_t sel;
	logic        sel_owner;
	logic        any_ext;
	logic [2:0]  eff_area;
	logic [2:0]  cfg_area;
	logic        need_gap;
	logic        burst_on;
	logic [7:0]  reg_rd;
	logic        ext_wait;
	logic        just_done;

	assign burst_on = r.ctrl_hi[CH_BURST_EN];
	// a master drops req one edge after its done pulse; that stale req must not start a second access
	assign just_done = r.done_cpu | r.done_xfer;
	assign ext_wait = ~I_WAIT_N & r.ctrl_lo[CL_WAIT_EN];

	always_comb
	begin
		// cpu has priority; fixed priority is simple and the cpu never starves
		sel_owner = ~I_CPU.req & I_XFER.req;
		sel       = sel_owner ? I_XFER : I_CPU;
		any_ext   = (I_CPU.req & I_CPU.ext) | (I_XFER.req & I_XFER.ext);
		eff_area  = I_ADVANCED ? area_of(sel.addr, r.ctrl_lo[CL_AREA_2M]) : AREA_ZERO;
		cfg_area  = I_ADVANCED ? eff_area : AREA_ZERO;
		need_gap  = r.last_rd & ((r.ctrl_hi[CH_IDLE_AREA] & ~sel.wr & (eff_area != r.last_area))
			| (r.ctrl_hi[CH_IDLE_RW] & sel.wr));
		case (I_AVS_ADDRESS)
			ADDR_WIDTH_REG:  reg_rd = r.width;
			ADDR_STATE_REG:  reg_rd = r.state_bits;
			ADDR_WAIT_HI:    reg_rd = r.wait_hi;
			ADDR_WAIT_LO:    reg_rd = r.wait_lo;
			ADDR_CTRL_HI:    reg_rd = r.ctrl_hi;
			ADDR_CTRL_LO:    reg_rd = r.ctrl_lo;
			ADDR_MODE_REG:   reg_rd = {5'h00, I_MCU_MODE};
			ADDR_STATUS_REG: reg_rd = {4'h0, r.fsm == ST_RELEASED, r.owner, r.area[1:0]};
			default:         reg_rd = 8'h00;
		endcase
	end

	always_comb
	begin
		next_r = r;
		next_r.done_cpu  = 1'b0;
		next_r.done_xfer = 1'b0;
		next_r.rd_ack    = 1'b0;
		// power-on values; straps are caught on the first clock after release
		if (!r.init_done)
		begin
			next_r.init_done = 1'b1;
			next_r.width     = (I_MCU_MODE == MODE_FOUR) ? RST_WIDTH_MODE4 : RST_WIDTH_ONES;
		end
		// registers: one-cycle answer, reads take one wait cycle
		if (I_AVS_WRITE)
		begin
			case (I_AVS_ADDRESS)
				ADDR_WIDTH_REG: next_r.width      = I_AVS_WRITEDATA;
				ADDR_STATE_REG: next_r.state_bits = I_AVS_WRITEDATA;
				ADDR_WAIT_HI:   next_r.wait_hi    = I_AVS_WRITEDATA;
				ADDR_WAIT_LO:   next_r.wait_lo    = I_AVS_WRITEDATA;
				ADDR_CTRL_HI:   next_r.ctrl_hi    = I_AVS_WRITEDATA;
				ADDR_CTRL_LO:   next_r.ctrl_lo    = I_AVS_WRITEDATA;
				default:        next_r.ctrl_lo    = r.ctrl_lo;
			endcase
		end
		if (I_AVS_READ & ~r.rd_ack)
		begin
			next_r.rd_ack = 1'b1;
			next_r.rdata  = reg_rd;
		end
		case (r.fsm)
			ST_IDLE:
			begin
				next_r.strobes = '1;
				if (r.ctrl_lo[CL_RELEASE_EN] & ~I_EXT_MASTER_REQUEST_N)
				begin
					next_r.fsm   = ST_RELEASED;
					next_r.ack_n = 1'b0;
				end
				else if (sel.req & ~sel.ext & ~just_done)
				begin
					// on-chip access: fixed timing, no program waits
					next_r.done_cpu  = ~sel_owner;
					next_r.done_xfer = sel_owner;
				end
				else if (sel.req & ~just_done)
				begin
					next_r.owner       = sel_owner;
					next_r.wr          = sel.wr;
					next_r.be          = sel.be;
					next_r.addr        = sel.addr;
					next_r.wdata       = sel.wdata;
					next_r.area        = eff_area;
					next_r.two_state   = ~r.state_bits[cfg_area];
					next_r.honour_wait = r.state_bits[cfg_area];
					next_r.pwait       = r.state_bits[cfg_area]
						? wait_field({r.wait_hi, r.wait_lo}, cfg_area) : CNT_ZERO;
					if (burst_on & (eff_area == AREA_ZERO))
					begin
						next_r.two_state   = ~r.ctrl_hi[CH_BURST_TWO];
						next_r.honour_wait = 1'b0;
						next_r.pwait       = CNT_ZERO;
					end
					next_r.fsm = need_gap ? ST_GAP : ST_T1;
				end
			end
			ST_GAP:
			begin
				next_r.last_rd = 1'b0;
				next_r.fsm     = ST_T1;
			end
			ST_T1:
			begin
				next_r.strobes.addr_strobe_n      = 1'b0;
				next_r.strobes.read_n             = r.wr;
				next_r.strobes.upper_byte_write_n = ~(r.wr & r.be[1]);
				next_r.strobes.lower_byte_write_n = ~(r.wr & r.be[0]);
				for (int k = 0; k < 4; k++)
					next_r.strobes.area_select_n[k] = ~(r.area == 3'(k));
				next_r.fsm = r.two_state ? ST_T3 : ST_T2;
			end
			ST_T2:
				next_r.fsm = (r.pwait != CNT_ZERO) ? ST_PWAIT : ST_T3;
			ST_PWAIT:
			begin
				next_r.pwait = r.pwait - CNT_ONE;
				if (r.pwait == CNT_ONE)
					next_r.fsm = ST_T3;
			end
			ST_T3:
			begin
				// wait input sampled only after program waits are spent
				if (!(r.honour_wait & ext_wait))
				begin
					next_r.strobes   = '1;
					next_r.done_cpu  = ~r.owner;
					next_r.done_xfer = r.owner;
					next_r.last_rd   = ~r.wr;
					next_r.last_area = r.area;
					next_r.fsm       = ST_IDLE;
				end
			end
			ST_RELEASED:
			begin
				next_r.strobes = '1;
				if (I_EXT_MASTER_REQUEST_N)
				begin
					next_r.ack_n   = 1'b1;
					next_r.last_rd = 1'b0;
					next_r.fsm     = ST_IDLE;
				end
			end
			default:
				next_r.fsm = ST_IDLE;
		endcase
	end

	always_ff @(posedge I_CLK or posedge I_RST)
	begin
		if (I_RST)
		begin
			r            <= '0;
			r.width      <= RST_WIDTH_ONES;
			r.state_bits <= RST_STATE;
			r.wait_hi    <= RST_WAIT;
			r.wait_lo    <= RST_WAIT;
			r.ctrl_hi    <= RST_CTRL_HI;
			r.ctrl_lo    <= RST_CTRL_LO;
			r.fsm        <= ST_IDLE;
			r.strobes    <= '1;
			r.ack_n      <= 1'b1;
		end
		else
			r <= next_r;
	end

	// 16-bit bus if any area (area 0 only in normal mode) is 16-bit or burst rom is on
	assign O_BURST_16          = burst_on | (I_ADVANCED ? ~&r.width : ~r.width[0]);
	assign O_RECLAIM_REQUEST_N = ~((r.fsm == ST_RELEASED) & r.ctrl_lo[CL_RECLAIM_EN] & any_ext);
	assign O_AVS_WAITREQUEST   = I_AVS_READ & ~r.rd_ack;
	assign O_AVS_READDATA      = r.rdata;
	assign O_CPU_DONE          = r.done_cpu;
	assign O_XFER_DONE         = r.done_xfer;
	assign O_BUS_ACK_N         = r.ack_n;
	assign O_ADDR              = r.addr;
	assign O_DATA_OUT          = r.wdata;
	assign O_DATA_OE           = r.wr & ~r.strobes.addr_strobe_n;
	assign O_STROBES           = r.strobes;

	AST_ACK_ONLY_RELEASED: assert property (@(posedge I_CLK) disable iff (I_RST)
		!O_BUS_ACK_N |-> O_STROBES.addr_strobe_n && O_STROBES.read_n)
		else $error("ack while strobes active");
	AST_RELEASE_REQ: assert property (@(posedge I_CLK) disable iff (I_RST)
		(r.fsm == ST_IDLE && r.ctrl_lo[CL_RELEASE_EN] && !I_EXT_MASTER_REQUEST_N && r.init_done) |=> !O_BUS_ACK_N)
		else $error("bus not released");
	AST_ONE_SELECT: assert property (@(posedge I_CLK) disable iff (I_RST)
		$countones(~O_STROBES.area_select_n) <= 1)
		else $error("two chip selects");
	AST_SELECT_WITH_STROBE: assert property (@(posedge I_CLK) disable iff (I_RST)
		O_STROBES.addr_strobe_n |-> &O_STROBES.area_select_n)
		else $error("select without strobe");
	AST_READ_NOT_WRITE: assert property (@(posedge I_CLK) disable iff (I_RST)
		!O_STROBES.read_n |-> O_STROBES.upper_byte_write_n && O_STROBES.lower_byte_write_n)
		else $error("read with write strobe");
	AST_TWO_STATE_LEN: assert property (@(posedge I_CLK) disable iff (I_RST)
		(r.fsm == ST_T1 && r.two_state) |=> r.fsm == ST_T3 ##1 r.fsm == ST_IDLE)
		else $error("2-state length wrong");
	AST_PWAIT_BOUND: assert property (@(posedge I_CLK) disable iff (I_RST)
		(r.fsm == ST_T2 && r.pwait == 2'h3) |=> r.fsm == ST_PWAIT [*3] ##1 r.fsm == ST_T3)
		else $error("three waits not inserted");
	AST_WAIT_EXTENDS: assert property (@(posedge I_CLK) disable iff (I_RST)
		(r.fsm == ST_T3 && r.honour_wait && ext_wait) |=> r.fsm == ST_T3)
		else $error("wait input ignored");
	AST_RECLAIM: assert property (@(posedge I_CLK) disable iff (I_RST)
		!O_RECLAIM_REQUEST_N |-> !O_BUS_ACK_N)
		else $error("reclaim outside release");
endmodule
`default_nettype wire

// File: hw/area_bus_pkg.sv
// area bus controller package: register map, field layout, reset values, types
// assumes one clock domain and an avalon-mm register port with byte addressing
package area_bus_pkg;
	// register byte addresses (lower 16 bits)
	localparam logic [15:0] ADDR_WIDTH_REG  = 16'hfed0;
	localparam logic [15:0] ADDR_STATE_REG  = 16'hfed1;
	localparam logic [15:0] ADDR_WAIT_HI    = 16'hfed2;
	localparam logic [15:0] ADDR_WAIT_LO    = 16'hfed3;
	localparam logic [15:0] ADDR_CTRL_HI    = 16'hfed4;
	localparam logic [15:0] ADDR_CTRL_LO    = 16'hfed5;
	localparam logic [15:0] ADDR_MODE_REG   = 16'hfed8;
	localparam logic [15:0] ADDR_STATUS_REG = 16'hfed9;
	// reset values
	localparam logic [7:0] RST_WIDTH_ONES  = 8'hff;
	localparam logic [7:0] RST_WIDTH_MODE4 = 8'h00;
	localparam logic [7:0] RST_STATE       = 8'hff;
	localparam logic [7:0] RST_WAIT        = 8'hff;
	localparam logic [7:0] RST_CTRL_HI     = 8'hd0;
	localparam logic [7:0] RST_CTRL_LO     = 8'h3c;
	localparam logic [2:0] MODE_FOUR       = 3'h4;
	// control high fields
	localparam int CH_IDLE_AREA  = 7;
	localparam int CH_IDLE_RW    = 6;
	localparam int CH_BURST_EN   = 5;
	localparam int CH_BURST_TWO  = 4;
	// control low fields
	localparam int CL_RELEASE_EN = 7;
	localparam int CL_RECLAIM_EN = 6;
	localparam int CL_AREA_2M    = 2;
	localparam int CL_WAIT_EN    = 0;
	// address split
	localparam int AREA_LSB_128K = 17;
	localparam int AREA_LSB_2M   = 21;
	localparam logic [2:0] AREA_ZERO = 3'h0;
	localparam logic [1:0] CNT_ZERO  = 2'h0;
	localparam logic [1:0] CNT_ONE   = 2'h1;

	typedef enum logic [2:0] {ST_IDLE, ST_GAP, ST_T1, ST_T2, ST_T3, ST_PWAIT, ST_RELEASED} bus_state_t;

	// internal master request
	typedef struct packed {
		logic        req;
		logic        wr;
		logic        ext;
		logic [23:0] addr;
		logic [1:0]  be;
		logic [15:0] wdata;
	} master_req_t;

	// external strobes
	typedef struct packed {
		logic       addr_strobe_n;
		logic       read_n;
		logic       upper_byte_write_n;
		logic       lower_byte_write_n;
		logic [3:0] area_select_n;
	} strobes_t;
endpackage

// File: testbench/ext_side_model.sv
// external side: wait-stretching memory and an external bus master
// assumes active-low strobes from the controller and one clock
`timescale 1ns/1ps
`default_nettype none
module ext_side_model
	import area_bus_pkg::*;
(
	// clock
	input  wire logic       i_clk,
	// controller pins
	input  wire strobes_t   i_strobes,
	input  wire logic       i_reclaim_n,
	output logic            o_wait_n,
	output logic            o_request_n,
	// bench commands
	input  wire logic [3:0] i_stretch,
	input  wire logic       i_grab
);
	logic [3:0] left = 4'h0;
	logic       as_q = 1'b1;
	logic       gave = 1'b0;
	// stretch starts at address strobe fall
	always @(posedge i_clk)
	begin
		as_q <= i_strobes.addr_strobe_n;
		if (as_q && !i_strobes.addr_strobe_n)
			left <= i_stretch;
		else if (left != 4'h0)
			left <= left - 4'h1;
	end
	assign o_wait_n = (left == 4'h0);
	// gives the bus back once, when asked
	always @(posedge i_clk)
	begin
		gave <= i_grab && (gave || !i_reclaim_n);
		o_request_n <= !i_grab || gave || !i_reclaim_n;
	end
endmodule
`default_nettype wire

// File: testbench/area_bus_ctrl_test.sv
// self-checking bench for the area bus controller
// assumes ext_side_model on the external pins
`timescale 1ns/1ps
`default_nettype none
module area_bus_ctrl_test;
	import area_bus_pkg::*;
	logic        clk = 1'b0, rst = 1'b1, adv = 1'b1, a_rd = 1'b0, a_wr = 1'b0, grab = 1'b0;
	logic [2:0]  mode = 3'h2;
	logic [15:0] a_addr = 16'h0;
	logic [7:0]  a_wd = 8'h0, a_rdata, rv, rnd, cnt = 8'h0;
	logic        a_wait, cpu_done, burst16, ack_n, reclaim_n, wait_n, req_n, saw_rc = 1'b0;
	logic        data_oe;
	logic [23:0] addr_out;
	master_req_t cpu = '0;
	strobes_t    stb;
	logic [3:0]  stretch = 4'h0, cs_seen = 4'hf;
	logic [11:0] exp_q[$];
	logic [7:0]  rst_tab[6] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hd0, 8'h3c};
	int          fail_count = 0, check_count = 0, cycles = 0;
	always #2.5 clk = ~clk;
	area_bus_ctrl dut (.I_CLK(clk), .I_RST(rst), .I_MCU_MODE(mode), .I_ADVANCED(adv),
		.I_AVS_ADDRESS(a_addr), .I_AVS_READ(a_rd), .I_AVS_WRITE(a_wr), .I_AVS_WRITEDATA(a_wd),
		.O_AVS_READDATA(a_rdata), .O_AVS_WAITREQUEST(a_wait), .I_CPU(cpu), .I_XFER('0),
		.O_CPU_DONE(cpu_done), .O_XFER_DONE(), .O_BURST_16(burst16), .I_WAIT_N(wait_n),
		.I_EXT_MASTER_REQUEST_N(req_n), .O_BUS_ACK_N(ack_n), .O_RECLAIM_REQUEST_N(reclaim_n),
		.O_ADDR(addr_out), .O_DATA_OUT(), .O_DATA_OE(data_oe), .O_STROBES(stb));
	ext_side_model far (.i_clk(clk), .i_strobes(stb), .i_reclaim_n(reclaim_n), .o_wait_n(wait_n),
		.o_request_n(req_n), .i_stretch(stretch), .i_grab(grab));
	task automatic check(input logic [11:0] seen, input logic [11:0] exp);
		check_count++;
		if (seen !== exp)
		begin
			fail_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task automatic tally_and_finish;
		$display("checks=%0d mismatches=%0d", check_count, fail_count);
		if (fail_count == 0 && check_count > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	task automatic reg_wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		a_addr <= a;
		a_wd <= d;
		a_wr <= 1'b1;
		@(negedge clk);
		while (a_wait !== 1'b0) @(negedge clk);
		@(posedge clk);
		a_wr <= 1'b0;
	endtask
	// data is settled by the negedge before the taking edge
	task automatic reg_rd(input logic [15:0] a);
		@(posedge clk);
		a_addr <= a;
		a_rd <= 1'b1;
		@(negedge clk);
		while (a_wait !== 1'b0) @(negedge clk);
		rv = a_rdata;
		@(posedge clk);
		a_rd <= 1'b0;
	endtask
	task automatic go(input logic [23:0] a, input logic w, input logic e);
		@(posedge clk);
		cpu <= '{1'b1, w, e, a, 2'h3, 16'($urandom)};
		@(negedge clk);
		while (cpu_done !== 1'b1) @(negedge clk);
		@(posedge clk);
		cpu.req <= 1'b0;
	endtask
	task automatic acc(input logic [23:0] a, input logic w, input logic e, input int n, input logic [3:0] cs);
		exp_q.push_back({8'(n), cs});
		go(a, w, e);
	endtask
	// cycles from request to done, and which selects went low
	always @(negedge clk)
	begin
		cycles++;
		if (cycles > 20000)
		begin
			fail_count++;
			tally_and_finish();
		end
		saw_rc |= (reclaim_n === 1'b0);
		if (cpu.req)
		begin
			cnt = cnt + 8'h1;
			cs_seen = cs_seen & stb.area_select_n;
			if (stb.lower_byte_write_n === 1'b0)
				check({11'h0, data_oe}, 12'h1);
			if (cpu_done === 1'b1 && cpu.ext)
				check(12'(addr_out ^ cpu.addr), 12'h0);
			if (cpu_done === 1'b1 && exp_q.size() > 0)
				check({cnt, cs_seen}, exp_q.pop_front());
		end
		else
		begin
			cnt = 8'h0;
			cs_seen = 4'hf;
		end
	end
	initial
	begin
		void'($urandom(32'hf145a587));
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		foreach (rst_tab[i])
		begin
			reg_rd(ADDR_WIDTH_REG + 16'(i));
			check({4'h0, rv}, {4'h0, rst_tab[i]});
		end
		reg_rd(16'hfed7);
		check({4'h0, rv}, 12'h0);
		rnd = 8'($urandom);
		reg_wr(ADDR_WAIT_HI, rnd);
		reg_rd(ADDR_WAIT_HI);
		check({4'h0, rv}, {4'h0, rnd});
		reg_wr(ADDR_CTRL_HI, 8'h00);
		@(negedge clk);
		check({11'h0, burst16}, 12'h0);
		for (int w = 0; w < 4; w++)
		begin
			reg_wr(ADDR_WAIT_LO, {4{2'(w)}});
			reg_wr(ADDR_WAIT_HI, {4{2'(w)}});
			acc(24'h000100, 1'b0, 1'b1, 5 + w, 4'he);
			acc(24'h200040, 1'b1, 1'b1, 5 + w, 4'hd);
			acc(24'h800000, 1'b0, 1'b1, 5 + w, 4'hf);
		end
		acc(24'h000200, 1'b0, 1'b0, 2, 4'hf);
		reg_wr(ADDR_STATE_REG, 8'hfe);
		reg_wr(ADDR_WAIT_LO, 8'h00);
		reg_wr(ADDR_CTRL_LO, 8'h3d);
		stretch <= 4'h3;
		acc(24'h000100, 1'b0, 1'b1, 4, 4'he);
		acc(24'h200000, 1'b0, 1'b1, 8, 4'hd);
		stretch <= 4'h0;
		reg_wr(ADDR_CTRL_HI, 8'h40);
		acc(24'h200000, 1'b0, 1'b1, 5, 4'hd);
		acc(24'h200000, 1'b1, 1'b1, 6, 4'hd);
		reg_wr(ADDR_CTRL_HI, 8'h80);
		acc(24'h000000, 1'b0, 1'b1, 4, 4'he);
		acc(24'h200000, 1'b0, 1'b1, 6, 4'hd);
		reg_wr(ADDR_CTRL_HI, 8'h20);
		@(negedge clk);
		check({11'h0, burst16}, 12'h1);
		reg_wr(ADDR_CTRL_HI, 8'h00);
		adv <= 1'b0;
		acc(24'h200000, 1'b0, 1'b1, 4, 4'he);
		adv <= 1'b1;
		reg_wr(ADDR_CTRL_LO, 8'hfc);
		grab <= 1'b1;
		repeat (4) @(posedge clk);
		check({11'h0, ack_n}, 12'h0);
		go(24'h200000, 1'b0, 1'b1);
		check({11'h0, saw_rc}, 12'h1);
		grab <= 1'b0;
		mode <= MODE_FOUR;
		rst <= 1'b1;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (2) @(posedge clk);
		reg_rd(ADDR_WIDTH_REG);
		check({4'h0, rv}, {4'h0, RST_WIDTH_MODE4});
		tally_and_finish();
	end
endmodule
`default_nettype wire
